//--- core/ppp_consts.svh
/*
  Timing and decode constants for the printer parallel port.
  Assumes a 40 MHz system clock.
*/
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH

// ==========================================================
// Address decode
`define PPP_DEC_HI_MASK    24'hff0000
`define PPP_DEC_HI_VALUE   24'h620000
`define PPP_REG_SEL_LSB    4
`define PPP_REG_SEL_MSB    8

// ==========================================================
// Register selects
`define PPP_SEL_DATA_OUT   5'h00
`define PPP_SEL_STATUS_IN  5'h01
`define PPP_SEL_IRQ_CLEAR  5'h02
`define PPP_SEL_TIMER_LOAD 5'h03

// ==========================================================
// Interrupt levels
`define PPP_LEVEL_PORT     3'h1
`define PPP_LEVEL_TIMER    3'h6

// ==========================================================
// Output strobe timing
`define PPP_CLK_PERIOD_NS  25
`define PPP_STROBE_NS      100
`define PPP_STROBE_CYCLES  ((`PPP_STROBE_NS + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)
`define PPP_SETUP_NS       50
`define PPP_SETUP_CYCLES   ((`PPP_SETUP_NS + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)

// ==========================================================
// Reset values
`define PPP_DATA_RESET     8'h00
`define PPP_TIMER_RESET    16'h0000

`endif

//--- core/ppp_pkg.sv
/*
  Types for the printer parallel port.
  Assumes ppp_consts.svh is available on the include path.
*/
package ppp_pkg;

  // ==========================================================
  // Bus cycle states
  typedef enum logic [3:0] {
    PPP_IDLE   = 4'b0001,
    PPP_ACCESS = 4'b0010,
    PPP_ACK    = 4'b0100,
    PPP_WAIT   = 4'b1000
  } ppp_bus_state_type;

endpackage : ppp_pkg

//--- core/ppp_port.sv
/*
  Printer parallel port: chip select decode, bus acknowledge, output data
  port with strobe, input status port, port and timer interrupts, and
  autovector request during level-one interrupt acknowledge.
  Assumes CPU bus signals and printer pins are asynchronous to i_clk.
*/
// Overview of operation
// [RULE_01] Select only on supervisor access to 62XYYX, qualified by timing strobe.
// [RULE_02] One read-not-write line sets direction; no separate strobes.
// [RULE_03] Every addressed bus cycle gets a transfer acknowledge.
// [RULE_04] Port A fixed 8-bit output, port B fixed 8-bit input.
// [RULE_05] Input bit 7 busy/ready also feeds handshake input four.
// [RULE_06] Port interrupt goes to level one; timer interrupt to level six.
// [RULE_07] Printer ready high raises the port interrupt request.
// [RULE_08] Port request is encoded as level one on active-low priority lines.
// [RULE_09] Interrupt acknowledge at level one asserts the autovector request.
// [RULE_10] Processor fetches handler pointer at vector times four, low 1K.
// [RULE_11] Service routine writes one byte; port drives it to printer.
// [RULE_12] Pacing is one byte per printer ready, no fixed bit rate.
// [RULE_13] Handshake one is input strobe, handshake two output strobe.
// [RULE_14] Printer pulses accept acknowledge once a character is taken.
// [RULE_15] Output data holds until next write; request clears when serviced.
`timescale 1ns/1ps
`include "ppp_consts.svh"

module ppp_port
  import ppp_pkg::*;
#(
  parameter int unsigned STROBE_CYCLES = `PPP_STROBE_CYCLES,
  parameter int unsigned SETUP_CYCLES  = `PPP_SETUP_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // CPU bus
  input  wire logic [23:0] i_cpu_addr,
  input  wire logic        i_cpu_supervisor,
  input  wire logic        i_cpu_strobe_n,
  input  wire logic        i_cpu_read_not_write_n,
  input  wire logic        i_access_timing_strobe,
  input  wire logic        i_cpu_iack,
  input  wire logic [7:0]  i_cpu_wdata,
  output logic      [7:0]  o_cpu_rdata,
  output logic             o_port_chip_enable_n,
  output logic             o_port_transfer_ack_n,
  output logic             o_autovector_request_n,
  output logic      [2:0]  o_cpu_priority_lines_n,
  output logic             o_irq_level_one_n,
  output logic             o_irq_level_six_n,
  // Printer side
  input  wire logic [7:0]  i_status_port,
  input  wire logic        i_input_strobe_line,
  input  wire logic        i_printer_accept_ack_n,
  output logic      [7:0]  o_data_port,
  output logic             o_output_strobe_line_n,
  output logic             o_accept_seen
);

  // ==========================================================
  // Input synchronisers
  logic [7:0]  status_meta_reg;
  logic [7:0]  status_sync_reg;
  logic [27:0] bus_meta_reg;
  logic [27:0] bus_sync_reg;
  logic [1:0]  hs_meta_reg;
  logic [1:0]  hs_sync_reg;
  logic [1:0]  hs_prev_reg;
  logic [7:0]  wdata_meta_reg;
  logic [7:0]  wdata_sync_reg;

  always_ff @(posedge i_clk)
  begin
    status_meta_reg <= i_status_port;
    status_sync_reg <= status_meta_reg;
    bus_meta_reg    <= {i_cpu_addr, i_cpu_supervisor, i_cpu_strobe_n,
                        i_cpu_read_not_write_n, i_access_timing_strobe};
    bus_sync_reg    <= bus_meta_reg;
    hs_meta_reg     <= {i_printer_accept_ack_n, i_input_strobe_line};
    hs_sync_reg     <= hs_meta_reg;
    hs_prev_reg     <= hs_sync_reg;
    // Write data crosses with the strobe, so it gets the same two-flop delay
    wdata_meta_reg  <= i_cpu_wdata;
    wdata_sync_reg  <= wdata_meta_reg;
  end

  wire logic [23:0] addr_s       = bus_sync_reg[27:4];
  wire logic        super_s      = bus_sync_reg[3];
  wire logic        strobe_n_s   = bus_sync_reg[2];
  wire logic        rnw_s        = bus_sync_reg[1];
  wire logic        timing_s     = bus_sync_reg[0];
  wire logic [7:0]  wdata_s      = wdata_sync_reg;
  wire logic        iack_s;
  logic             iack_meta_reg;
  logic             iack_sync_reg;

  always_ff @(posedge i_clk)
  begin
    iack_meta_reg <= i_cpu_iack;
    iack_sync_reg <= iack_meta_reg;
  end
  assign iack_s = iack_sync_reg;

  // ==========================================================
  // Decode
  wire logic       addr_hit   = ((addr_s & `PPP_DEC_HI_MASK) == `PPP_DEC_HI_VALUE); // [RULE_01]
  wire logic       decode_en  = addr_hit && super_s && !strobe_n_s && !iack_s;     // [RULE_01]
  wire logic       select     = decode_en && timing_s;                              // [RULE_01]
  wire logic [4:0] reg_sel    = addr_s[`PPP_REG_SEL_MSB:`PPP_REG_SEL_LSB];
  // Read-not-write is the sole direction signal
  wire logic       is_read    = rnw_s;                                              // [RULE_02]
  wire logic       ready_bit  = status_sync_reg[7];
  // Handshake input four is the same printer ready line as bit 7
  wire logic       hs_four    = ready_bit;                                          // [RULE_05]
  wire logic       in_strobe_rise = hs_sync_reg[0] && !hs_prev_reg[0];              // [RULE_13]
  wire logic       accept_fall    = !hs_sync_reg[1] && hs_prev_reg[1];

  // ==========================================================
  // Bus cycle sequencer
  ppp_bus_state_type state_reg;
  ppp_bus_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PPP_IDLE:   if (select) state_next = PPP_ACCESS;
      PPP_ACCESS: state_next = PPP_ACK;
      PPP_ACK:    state_next = PPP_WAIT;
      PPP_WAIT:   if (strobe_n_s) state_next = PPP_IDLE;
      default:    state_next = PPP_IDLE;
    endcase
  end

  wire logic do_access = (state_reg == PPP_ACCESS);
  wire logic do_write  = do_access && !is_read;
  wire logic do_read   = do_access && is_read;

  // ==========================================================
  // Port state
  logic [7:0]  data_reg;
  logic [7:0]  latched_in_reg;
  logic        hs_four_prev_reg;
  logic        port_irq_reg;
  logic [15:0] timer_load_reg;
  logic [15:0] timer_cnt_reg;
  logic        timer_irq_reg;
  logic [3:0]  strobe_cnt_reg;
  logic        strobe_busy_reg;

  wire logic ready_rise  = hs_four && !hs_four_prev_reg;                         // [RULE_07]
  wire logic irq_clear   = do_write && (reg_sel == `PPP_SEL_IRQ_CLEAR ||
                                        reg_sel == `PPP_SEL_DATA_OUT);          // [RULE_15]
  wire logic timer_clear = do_write && (reg_sel == `PPP_SEL_TIMER_LOAD);
  wire logic timer_wrap  = (timer_load_reg != `PPP_TIMER_RESET) &&
                           (timer_cnt_reg == 16'h0000);
  wire logic start_strobe = do_write && (reg_sel == `PPP_SEL_DATA_OUT);         // [RULE_11]
  wire logic [3:0] strobe_total = 4'(SETUP_CYCLES + STROBE_CYCLES);

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg        <= PPP_IDLE;
      data_reg         <= `PPP_DATA_RESET;
      latched_in_reg   <= 8'h00;
      hs_four_prev_reg <= 1'b0;
      port_irq_reg     <= 1'b0;
      timer_load_reg   <= `PPP_TIMER_RESET;
      timer_cnt_reg    <= `PPP_TIMER_RESET;
      timer_irq_reg    <= 1'b0;
      strobe_cnt_reg   <= 4'h0;
      strobe_busy_reg  <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      hs_four_prev_reg <= hs_four;
      // Output byte holds until software writes again
      if (start_strobe)
        data_reg <= wdata_s;                                                      // [RULE_15]
      if (in_strobe_rise)
        latched_in_reg <= status_sync_reg;                                        // [RULE_13]
      // Set beats clear so a ready edge during service is not lost
      if (ready_rise)
        port_irq_reg <= 1'b1;                                                     // [RULE_07]
      else if (irq_clear)
        port_irq_reg <= 1'b0;                                                     // [RULE_15]
      if (timer_clear)
      begin
        timer_load_reg <= {timer_load_reg[7:0], wdata_s};
        timer_cnt_reg  <= {timer_load_reg[7:0], wdata_s};
      end
      else if (timer_wrap)
        timer_cnt_reg <= timer_load_reg;
      else if (timer_cnt_reg != 16'h0000)
        timer_cnt_reg <= timer_cnt_reg - 16'h0001;
      // Set beats clear so a wrap during the clearing write is not lost
      if (timer_wrap)
        timer_irq_reg <= 1'b1;                                                    // [RULE_06]
      else if (timer_clear)
        timer_irq_reg <= 1'b0;
      // One strobe per written byte; pacing left to software
      if (start_strobe)
      begin
        strobe_busy_reg <= 1'b1;                                                  // [RULE_12]
        strobe_cnt_reg  <= 4'h0;
      end
      else if (strobe_busy_reg)
      begin
        strobe_cnt_reg <= strobe_cnt_reg + 4'h1;
        if (strobe_cnt_reg == strobe_total)
          strobe_busy_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  wire logic [7:0] read_mux = (reg_sel == `PPP_SEL_STATUS_IN) ? status_sync_reg :
                              (reg_sel == `PPP_SEL_DATA_OUT)  ? data_reg :
                              (reg_sel == `PPP_SEL_IRQ_CLEAR) ? latched_in_reg :
                              8'h00;
  // Strobe waits out data setup before going low
  wire logic strobe_low = strobe_busy_reg &&
                          (strobe_cnt_reg >= 4'(SETUP_CYCLES)) &&
                          (strobe_cnt_reg < strobe_total);                        // [RULE_13]
  wire logic iack_lvl_one = iack_s && !strobe_n_s &&
                            (addr_s[3:1] == `PPP_LEVEL_PORT);                     // [RULE_09]
  // Highest active level wins on the encoded priority lines
  wire logic [2:0] level_code = timer_irq_reg ? `PPP_LEVEL_TIMER :
                                port_irq_reg  ? `PPP_LEVEL_PORT : 3'h0;          // [RULE_08]

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_cpu_rdata            <= 8'h00;
      o_port_chip_enable_n   <= 1'b1;
      o_port_transfer_ack_n  <= 1'b1;
      o_autovector_request_n <= 1'b1;
      o_cpu_priority_lines_n <= 3'h7;
      o_irq_level_one_n      <= 1'b1;
      o_irq_level_six_n      <= 1'b1;
      o_data_port            <= `PPP_DATA_RESET;
      o_output_strobe_line_n <= 1'b1;
      o_accept_seen          <= 1'b0;
    end
    else
    begin
      if (do_read)
        o_cpu_rdata <= read_mux;                                                  // [RULE_04]
      o_port_chip_enable_n   <= !(state_reg != PPP_IDLE && !strobe_n_s);         // [RULE_01]
      o_port_transfer_ack_n  <= !((state_reg == PPP_ACK || state_reg == PPP_WAIT)
                                  && !strobe_n_s);                               // [RULE_03]
      o_autovector_request_n <= !iack_lvl_one;                                    // [RULE_09]
      o_cpu_priority_lines_n <= ~level_code;                                      // [RULE_08]
      o_irq_level_one_n      <= !port_irq_reg;                                    // [RULE_06]
      o_irq_level_six_n      <= !timer_irq_reg;                                   // [RULE_06]
      o_data_port            <= data_reg;                                         // [RULE_04]
      o_output_strobe_line_n <= !strobe_low;                                      // [RULE_13]
      o_accept_seen          <= accept_fall;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_ready_edge;
    !hs_four_prev_reg && hs_four;
  endsequence

  a_irq_on_ready: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_07]
    s_ready_edge |-> ##1 port_irq_reg ##1 !o_irq_level_one_n)
    else $error("ready edge did not raise port interrupt");

  a_ack_follows: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_03]
    (state_reg == PPP_IDLE && select) |-> ##3 (!o_port_transfer_ack_n || strobe_n_s))
    else $error("addressed cycle not acknowledged");

  a_sel_needs_super: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_01]
    $fell(o_port_chip_enable_n) |->
      ($past(super_s, 2) && $past(addr_hit, 2) && $past(timing_s, 2)))
    else $error("select without supervisor decode");

  a_data_holds: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_15]
    !start_strobe |=> $stable(data_reg))
    else $error("output data changed without write");

  a_write_drives: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_11]
    start_strobe |-> ##2 (o_data_port == $past(wdata_s, 2)))
    else $error("written byte not driven to printer");

  a_clear_irq: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_15]
    (irq_clear && !ready_rise) |=> !port_irq_reg)
    else $error("serviced request did not clear");

  a_level_one: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_08]
    (port_irq_reg && !timer_irq_reg) |=> (o_cpu_priority_lines_n == 3'h6))
    else $error("port request not encoded as level one");

  a_autovector: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_09]
    iack_lvl_one |=> !o_autovector_request_n)
    else $error("no autovector at level one");

  a_strobe_width: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_13]
    $fell(o_output_strobe_line_n) |-> !o_output_strobe_line_n [*4])
    else $error("output strobe too short");

  a_hs_four: assert property (@(posedge i_clk) disable iff (i_reset) // [RULE_05]
    $rose(port_irq_reg) |-> $past(status_sync_reg[7]))
    else $error("port interrupt raised without bit 7 high");

endmodule : ppp_port

//--- test/ppp_port_test.sv
/*
  Self-checking bench for the printer parallel port.
  Assumes the printer model beside it; the bus is driven at falling edges.
*/
`timescale 1ns/1ps
module ppp_port_test;
  import ppp_pkg::*;
  typedef struct {logic [23:0] a; logic s; logic r; logic [7:0] w; logic k; logic [7:0] d;}
    ppp_row_type;
  logic clk = 0, rst = 1, sup = 0, stb_n = 1, rnw = 1, ts = 0, iack = 0, istb = 0;
  logic [23:0] addr = 24'h000000;
  logic [7:0]  wdata = 8'h00, rd, status, dport, rdata;
  logic        acc_n, ce_n, ack_n, av_n, irq1_n, irq6_n, ostb_n, seen;
  logic [2:0]  prio;
  int          err_count = 0, checks = 0, acc_cnt = 0, n;
  ppp_row_type rows [7] = '{
    '{24'h620000, 1, 0, 8'h5a, 1, 8'h00}, '{24'h620000, 1, 1, 8'h00, 1, 8'h5a},
    '{24'h620000, 0, 0, 8'h33, 0, 8'h00}, '{24'h630000, 1, 0, 8'h33, 0, 8'h00},
    '{24'h620000, 1, 1, 8'h00, 1, 8'h5a}, '{24'h6200f0, 1, 1, 8'h00, 1, 8'h00},
    '{24'h62fe0e, 1, 1, 8'h00, 1, 8'h5a}};
  always #12.5 clk = ~clk;
  always @(negedge clk) if (seen === 1'b1) acc_cnt++;
  ppp_port #(.STROBE_CYCLES(4), .SETUP_CYCLES(2)) DUT (
    .i_clk(clk), .i_reset(rst), .i_cpu_addr(addr), .i_cpu_supervisor(sup),
    .i_cpu_strobe_n(stb_n), .i_cpu_read_not_write_n(rnw), .i_access_timing_strobe(ts),
    .i_cpu_iack(iack), .i_cpu_wdata(wdata), .o_cpu_rdata(rdata),
    .o_port_chip_enable_n(ce_n), .o_port_transfer_ack_n(ack_n),
    .o_autovector_request_n(av_n), .o_cpu_priority_lines_n(prio),
    .o_irq_level_one_n(irq1_n), .o_irq_level_six_n(irq6_n), .i_status_port(status),
    .i_input_strobe_line(istb), .i_printer_accept_ack_n(acc_n), .o_data_port(dport),
    .o_output_strobe_line_n(ostb_n), .o_accept_seen(seen));
  ppp_printer_model printer (.i_clk(clk), .i_reset(rst), .i_data_port(dport),
    .i_strobe_n(ostb_n), .o_status(status), .o_accept_ack_n(acc_n));
  // ==========================================================
  // Checking and bus tasks
  task automatic tally_and_finish;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_low(ref logic sig, input int lim);
    n = 0;
    while (sig !== 1'b0 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_low
  // Refused cycles give no answer, so the strobe is let go after the bound
  task automatic bus(input ppp_row_type t, output logic [7:0] d);
    @(negedge clk);
    {addr, sup, rnw, wdata, stb_n, ts} = {t.a, t.s, t.r, t.w, 2'b01};
    wait_low(ack_n, 20);
    chk({7'h00, ack_n === 1'b0}, {7'h00, t.k});
    chk({7'h00, ce_n}, {7'h00, !t.k});
    @(posedge clk);
    d = rdata;
    @(negedge clk);
    {stb_n, ts} = 2'b10;
    repeat (6) @(negedge clk);
    chk({7'h00, ack_n}, 8'h01);
  endtask : bus
  task automatic wr(input logic [23:0] a, input logic [7:0] w);
    bus('{a, 1, 0, w, 1, 8'h00}, rd);
  endtask : wr
  task automatic iack_cyc(input logic [2:0] lvl, input logic exp);
    @(negedge clk);
    {addr, iack, stb_n, sup} = {20'h00000, lvl, 1'b0, 3'b101};
    repeat (5) @(negedge clk);
    chk({7'h00, av_n}, {7'h00, exp});
    {iack, stb_n} = 2'b01;
    repeat (4) @(negedge clk);
  endtask : iack_cyc
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 0;
    chk({ack_n, ce_n, av_n, irq1_n, irq6_n, prio}, 8'hff);
    chk(dport, 8'h00);
    wait_low(irq1_n, 60);
    chk({7'h00, irq1_n}, 8'h00);
    chk({5'h00, prio}, 8'h06);
    foreach (rows[i])
    begin
      bus(rows[i], rd);
      if (rows[i].r && rows[i].k)
        chk(rd, rows[i].d);
    end
    wait_low(irq1_n, 100);
    chk({7'h00, irq1_n}, 8'h00);
    chk(printer.rx_byte, 8'h5a);
    chk(printer.rx_hold, 8'h5a);
    chk(printer.low_len[7:0], 8'h04);
    chk(acc_cnt[7:0], 8'h01);
    chk(dport, 8'h5a);
    bus('{24'h620010, 1, 1, 8'h00, 1, 8'h00}, rd);
    chk(rd, 8'h85);
    @(negedge clk);
    istb = 1;
    repeat (4) @(negedge clk);
    istb = 0;
    bus('{24'h620020, 1, 1, 8'h00, 1, 8'h00}, rd);
    chk(rd, 8'h85);
    wr(24'h620020, 8'h00);
    chk({5'h00, irq1_n, irq6_n, 1'b0}, 8'h06);
    chk({5'h00, prio}, 8'h07);
    iack_cyc(3'h1, 1'b0);
    iack_cyc(3'h6, 1'b1);
    wr(24'h620030, 8'h01);
    wr(24'h620030, 8'h00);
    wait_low(irq6_n, 400);
    chk({7'h00, irq6_n}, 8'h00);
    chk({5'h00, prio}, 8'h01);
    wr(24'h620030, 8'h00);
    wr(24'h620030, 8'h00);
    chk({7'h00, irq6_n}, 8'h01);
    chk({5'h00, prio}, 8'h07);
    tally_and_finish();
  end
endmodule : ppp_port_test

//--- test/ppp_printer_model.sv
/*
  Behavioural printer on the far side of the parallel port.
  Assumes one strobe at a time and a design clocked on i_clk.
*/
`timescale 1ns/1ps
// ==========================================================
// Printer model
module ppp_printer_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Port side
  input  wire logic [7:0] i_data_port,
  input  wire logic       i_strobe_n,
  output logic      [7:0] o_status,
  output logic            o_accept_ack_n
);
  logic       ready_reg;
  logic [7:0] rx_byte;
  logic [7:0] rx_hold;
  int         low_len;
  int         rx_count;
  assign o_status = {ready_reg, 7'h05};
  initial
  begin
    ready_reg      = 1'b0;
    o_accept_ack_n = 1'b1;
    rx_byte        = 8'h00;
    rx_hold        = 8'h00;
    low_len        = 0;
    rx_count       = 0;
    @(negedge i_reset);
    repeat (10) @(posedge i_clk);
    ready_reg <= 1'b1;
    forever
    begin
      @(negedge i_strobe_n);
      rx_byte = i_data_port;
      ready_reg <= 1'b0;
      low_len = 0;
      // Sample just after each edge so the strobe's own update has landed
      while (i_strobe_n === 1'b0)
      begin
        @(posedge i_clk);
        #1;
        low_len++;
      end
      rx_hold = i_data_port;
      rx_count++;
      repeat (6) @(posedge i_clk);
      o_accept_ack_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_accept_ack_n <= 1'b1;
      ready_reg      <= 1'b1;
    end
  end
endmodule : ppp_printer_model
